/* File: src/sor_defs.svh */
`ifndef SOR_DEFS_SVH
`define SOR_DEFS_SVH

// Register indexes; byte address is four times the index
`define SOR_IDX_OPT_B 16'h001E
`define SOR_IDX_OPT_A 16'h001F
`define SOR_IDX_OSC 16'hFFD0
`define SOR_ADDR_W 18

// Option A field positions
`define SOR_A_WD_PERIOD 7
`define SOR_A_LVM_OFF 4
`define SOR_A_SHORT_REC 2
`define SOR_A_STOP_EN 1
`define SOR_A_WD_DIS 0
`define SOR_A_MASK 8'h97

// Option B field positions
`define SOR_B_IRQ_PUD 7
`define SOR_B_TRIP_HI 4
`define SOR_B_TRIP_LO 3
`define SOR_B_I2C_ROUTE 1
`define SOR_B_OSC_HALT 0
`define SOR_B_MASK 8'h83
`define SOR_B_TRIP_MASK 8'h18

// Oscillator option byte
`define SOR_OSC_TYPE 7
`define SOR_OSC_BLANK 8'hFF

// Reset values
`define SOR_OPT_RST 8'h00
`define SOR_DATA_ZERO 32'h0000_0000

// Watchdog periods in internal oscillator cycles
`define SOR_WD_SHORT 19'h01FF0
`define SOR_WD_LONG 19'h3FFF0

// Stop recovery in internal oscillator cycles
`define SOR_REC_SHORT 32
`define SOR_REC_LONG 4096
`define SOR_REC_W 13

`endif

/* File: src/sor_pkg.sv */
package sor_pkg;

	// Stop and recovery sequencing
	typedef enum logic [1:0] {
		SOR_RUN,
		SOR_STOP,
		SOR_WAKE
	} sor_rec_e;

	// One option byte
	typedef logic [7:0] sor_byte_t;

endpackage

/* File: src/sor_top.sv */
`timescale 1ns/100ps
`include "sor_defs.svh"

// How it works
// - Each option register takes exactly one software write after every reset.
// - Any reset clears all bits of both option registers except the two trip select bits.
// - Trip select bits clear on power-on reset only; writable once per power-on.
// - Both option registers read back their contents at any time.
// - Option B sits at the lower of two adjacent indexes, option A above.
// - Period select set gives 2^13-2^4 cycles, clear gives 2^18-2^4.
// - Low-voltage monitor off bit set turns the monitor off.
// - Short recovery bit selects 32 cycles stop exit, else 4096.
// - Leaving stop through reset always uses the long recovery delay.
// - Stop enable clear makes the stop instruction an illegal opcode.
// - Watchdog disable bit set turns the watchdog off.
// - Pull-up disable bit set disconnects the IRQ pin pull-up.
// - Pin route bit selects which pin pair carries I2C data and clock.
// - Oscillator halt bit set stops the internal oscillator during stop.
// - Oscillator option byte is sampled after power-on reset.
// - Oscillator type bit one selects crystal, zero RC; plain resets keep it.
// - Only flash programming changes the oscillator byte; bus writes ignored.
module sor_top #(
	parameter int REC_SHORT = `SOR_REC_SHORT,
	parameter int REC_LONG = `SOR_REC_LONG
) (
	input wire logic mclk, // Bus clock
	input wire logic rstn, // Any reset, sync, low
	input wire logic por_rstn, // Power-on reset, sync, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [`SOR_ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [7:0] osc_flash_byte, // Oscillator byte from flash
	input wire logic osc_tick, // One internal oscillator cycle
	input wire logic stop_instr, // Stop instruction executed
	input wire logic stop_wake, // Interrupt or break wake
	output logic [18:0] watchdog_period, // Watchdog timeout cycles
	output logic watchdog_disable, // Watchdog off
	output logic low_voltage_monitor_off, // Monitor off
	output logic [1:0] trip_voltage_select, // Trip point hi, lo
	output logic irq_pullup_disable, // IRQ pull-up off
	output logic i2c_pin_route, // I2C pin pair select
	output logic oscillator_type_bit, // 1 crystal, 0 RC
	output logic osc_run, // Internal oscillator enable
	output logic cpu_clk_hold, // CPU clocks held
	output logic stop_enter, // Stop accepted pulse
	output logic illegal_opcode // Illegal stop pulse
);

	// Short recovery needs at least one tick
	if (REC_SHORT < 1) begin : g_short_low
		$error("short recovery count must be positive");
	end

	// Long recovery needs at least one tick
	if (REC_LONG < 1) begin : g_long_low
		$error("long recovery count must be positive");
	end

	// Counter holds the count minus one
	if (REC_SHORT > (1 << `SOR_REC_W)) begin : g_short_wide
		$error("short recovery count exceeds counter width");
	end

	// Same limit for the long count
	if (REC_LONG > (1 << `SOR_REC_W)) begin : g_long_wide
		$error("long recovery count exceeds counter width");
	end

	localparam logic [`SOR_REC_W-1:0] REC_S = `SOR_REC_W'(REC_SHORT - 1);
	localparam logic [`SOR_REC_W-1:0] REC_L = `SOR_REC_W'(REC_LONG - 1);

	// Address match on a register index
	function automatic logic sor_hit(
		input logic [`SOR_ADDR_W-1:0] addr,
		input logic [15:0] idx
	);
		sor_hit = (addr == {idx, 2'b00});
	endfunction

	// Option byte widened to the bus
	function automatic logic [31:0] sor_wide(input sor_pkg::sor_byte_t b);
		sor_wide = {24'h00_0000, b};
	endfunction

	// Trip pair placed at its option B positions
	function automatic sor_pkg::sor_byte_t sor_trip_place(input logic [1:0] trip);
		sor_trip_place = `SOR_OPT_RST;
		sor_trip_place[`SOR_B_TRIP_HI] = trip[1];
		sor_trip_place[`SOR_B_TRIP_LO] = trip[0];
	endfunction

	// Recovery reload for the selected exit delay
	function automatic logic [`SOR_REC_W-1:0] sor_rec_load(input logic short_sel);
		sor_rec_load = short_sel ? REC_S : REC_L;
	endfunction

	sor_pkg::sor_byte_t opt_a_q;
	sor_pkg::sor_byte_t opt_b_q;
	sor_pkg::sor_byte_t osc_byte_q;
	logic a_used_q;
	logic b_used_q;
	logic trip_used_q;
	logic [1:0] trip_q;
	logic osc_seen_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic hit_a;
	logic hit_b;
	logic hit_osc;
	logic acc_first;
	logic wr_done;
	sor_pkg::sor_byte_t opt_a_wr;
	sor_pkg::sor_byte_t opt_b_wr;
	logic bad_access;
	logic stop_seen;
	sor_pkg::sor_rec_e rec_q;
	logic [`SOR_REC_W-1:0] rec_cnt_q;
	logic stop_enter_q;
	logic illegal_q;
	logic [18:0] wd_period_q;

	// Register decode
	assign hit_a = sor_hit(paddr, `SOR_IDX_OPT_A);
	assign hit_b = sor_hit(paddr, `SOR_IDX_OPT_B);
	assign hit_osc = sor_hit(paddr, `SOR_IDX_OSC);

	// First access cycle and completing write
	assign acc_first = psel & penable & ~pready_q;
	assign wr_done = psel & penable & pready_q & pwrite;

	// Write bytes with reserved bits forced to zero
	assign opt_a_wr = pwdata[7:0] & `SOR_A_MASK;
	assign opt_b_wr = pwdata[7:0] & `SOR_B_MASK;

	// Unmapped index, or a bus write to the flash byte
	assign bad_access = ~(hit_a | hit_b | hit_osc) | (hit_osc & pwrite);

	// Stop instruction seen while running
	assign stop_seen = stop_instr && rec_q == sor_pkg::SOR_RUN;

	// One wait state, answer registered
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= acc_first;
		end
	end

	// Error flag set on the first access cycle
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			pslverr_q <= 1'b0;
		end else if (acc_first) begin
			pslverr_q <= bad_access;
		end else if (pready_q) begin
			pslverr_q <= 1'b0;
		end
	end

	// Read data captured before completion, zero otherwise
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			prdata_q <= `SOR_DATA_ZERO;
		end else if (acc_first) begin
			if (pwrite) begin
				prdata_q <= `SOR_DATA_ZERO;
			end else if (hit_a) begin
				prdata_q <= sor_wide(opt_a_q);
			end else if (hit_b) begin
				prdata_q <= sor_wide(opt_b_q | sor_trip_place(trip_q));
			end else if (hit_osc) begin
				prdata_q <= sor_wide(osc_byte_q);
			end else begin
				prdata_q <= `SOR_DATA_ZERO;
			end
		end else if (pready_q) begin
			prdata_q <= `SOR_DATA_ZERO;
		end
	end

	// Option A, write once per reset
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			opt_a_q <= `SOR_OPT_RST;
		end else if (wr_done && hit_a && !a_used_q) begin
			opt_a_q <= opt_a_wr;
		end
	end

	// Option A write-once flag
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			a_used_q <= 1'b0;
		end else if (wr_done && hit_a) begin
			a_used_q <= 1'b1;
		end
	end

	// Option B ordinary bits, write once per reset; trip positions stay zero here
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			opt_b_q <= `SOR_OPT_RST;
		end else if (wr_done && hit_b && !b_used_q) begin
			opt_b_q <= opt_b_wr;
		end
	end

	// Option B write-once flag
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			b_used_q <= 1'b0;
		end else if (wr_done && hit_b) begin
			b_used_q <= 1'b1;
		end
	end

	// Trip select bits, power-on reset only
	always_ff @(posedge mclk) begin
		if (!por_rstn) begin
			trip_q <= 2'h0;
		end else if (wr_done && hit_b && !trip_used_q) begin
			trip_q <= {pwdata[`SOR_B_TRIP_HI], pwdata[`SOR_B_TRIP_LO]};
		end
	end

	// Trip write-once flag survives plain resets
	always_ff @(posedge mclk) begin
		if (!por_rstn) begin
			trip_used_q <= 1'b0;
		end else if (wr_done && hit_b) begin
			trip_used_q <= 1'b1;
		end
	end

	// Oscillator byte captured once after power-on
	always_ff @(posedge mclk) begin
		if (!por_rstn) begin
			osc_seen_q <= 1'b0;
		end else begin
			osc_seen_q <= 1'b1;
		end
	end

	// Capture keeps value across other resets
	always_ff @(posedge mclk) begin
		if (!por_rstn) begin
			osc_byte_q <= `SOR_OSC_BLANK;
		end else if (!osc_seen_q) begin
			osc_byte_q <= osc_flash_byte;
		end
	end

	// Watchdog period from select bit
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			wd_period_q <= `SOR_WD_LONG;
		end else if (opt_a_q[`SOR_A_WD_PERIOD]) begin
			wd_period_q <= `SOR_WD_SHORT;
		end else begin
			wd_period_q <= `SOR_WD_LONG;
		end
	end

	// Stop sequencing; reset lands in long recovery
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			rec_q <= sor_pkg::SOR_WAKE;
		end else begin
			case (rec_q)
				sor_pkg::SOR_RUN: begin
					if (stop_seen && opt_a_q[`SOR_A_STOP_EN]) begin
						rec_q <= sor_pkg::SOR_STOP;
					end
				end
				sor_pkg::SOR_STOP: begin
					if (stop_wake) begin
						rec_q <= sor_pkg::SOR_WAKE;
					end
				end
				sor_pkg::SOR_WAKE: begin
					if (osc_tick && rec_cnt_q == '0) begin
						rec_q <= sor_pkg::SOR_RUN;
					end
				end
				default: begin
					rec_q <= sor_pkg::SOR_RUN;
				end
			endcase
		end
	end

	// Recovery counter, loaded on wake, counts oscillator ticks
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			rec_cnt_q <= sor_rec_load(1'b0);
		end else begin
			case (rec_q)
				sor_pkg::SOR_STOP: begin
					if (stop_wake) begin
						rec_cnt_q <= sor_rec_load(opt_a_q[`SOR_A_SHORT_REC]);
					end
				end
				sor_pkg::SOR_WAKE: begin
					if (osc_tick && rec_cnt_q != '0) begin
						rec_cnt_q <= rec_cnt_q - 1'b1;
					end
				end
				default: begin
					rec_cnt_q <= rec_cnt_q;
				end
			endcase
		end
	end

	// Stop accepted pulse
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			stop_enter_q <= 1'b0;
		end else begin
			stop_enter_q <= stop_seen && opt_a_q[`SOR_A_STOP_EN];
		end
	end

	// Stop refused as an illegal opcode
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= stop_seen && !opt_a_q[`SOR_A_STOP_EN];
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign watchdog_period = wd_period_q;
	assign watchdog_disable = opt_a_q[`SOR_A_WD_DIS];
	assign low_voltage_monitor_off = opt_a_q[`SOR_A_LVM_OFF];
	assign trip_voltage_select = trip_q;
	assign irq_pullup_disable = opt_b_q[`SOR_B_IRQ_PUD];
	assign i2c_pin_route = opt_b_q[`SOR_B_I2C_ROUTE];
	assign oscillator_type_bit = osc_byte_q[`SOR_OSC_TYPE];
	assign stop_enter = stop_enter_q;
	assign illegal_opcode = illegal_q;

	// Oscillator follows the stop state and the halt bit
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			osc_run <= 1'b1;
		end else begin
			osc_run <= !(rec_q == sor_pkg::SOR_STOP && opt_b_q[`SOR_B_OSC_HALT]);
		end
	end

	// Clock hold until recovery has run out
	always_ff @(posedge mclk) begin
		if (!rstn || !por_rstn) begin
			cpu_clk_hold <= 1'b1;
		end else begin
			cpu_clk_hold <= rec_q != sor_pkg::SOR_RUN;
		end
	end

endmodule

/* File: verif/sor_top_asserts.sv */
`timescale 1ns/100ps
module sor_top_asserts #(
	parameter int REC_LONG = 4096
) (
	input wire logic mclk, // Clock
	input wire logic rstn, // Reset
	input wire logic por_rstn, // Power-on
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [18:0] watchdog_period, // Period
	input wire logic watchdog_disable, // Wd off
	input wire logic low_voltage_monitor_off, // Lvm off
	input wire logic [1:0] trip_voltage_select, // Trip
	input wire logic irq_pullup_disable, // Pull-up off
	input wire logic oscillator_type_bit, // Osc type
	input wire logic osc_run, // Osc on
	input wire logic cpu_clk_hold, // Clock hold
	input wire logic stop_enter, // Stop
	input wire logic illegal_opcode // Illegal
);
	// One clock; plain reset unless named
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_ready_gap: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready timing wrong");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error flag outside completion");
	a_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside completion");
	a_reset_clears: assert property (disable iff (!por_rstn) !rstn |-> ##2 watchdog_period == 19'h3FFF0
		&& !watchdog_disable && !low_voltage_monitor_off && !irq_pullup_disable)
		else $error("option bits not cleared");
	a_trip_keep: assert property (disable iff (!por_rstn) !rstn |=> $stable(trip_voltage_select))
		else $error("trip bits lost on plain reset");
	a_osc_keep: assert property (disable iff (!por_rstn) $past(por_rstn, 3) |-> $stable(oscillator_type_bit))
		else $error("oscillator type changed");
	a_period_pair: assert property (watchdog_period == 19'h01FF0 || watchdog_period == 19'h3FFF0)
		else $error("bad watchdog period");
	a_stop_excl: assert property (stop_enter |-> !illegal_opcode ##1 cpu_clk_hold)
		else $error("stop entry wrong");
	a_halt_stop: assert property (!osc_run |-> cpu_clk_hold)
		else $error("oscillator off while running");
	a_hold_reset: assert property ($rose(rstn) && REC_LONG >= 8 |-> cpu_clk_hold [*8])
		else $error("short recovery after reset");
endmodule

/* File: verif/sor_top_bench.sv */
`timescale 1ns/100ps
`include "sor_defs.svh"
module sor_top_bench;
	localparam logic [17:0] AA = {`SOR_IDX_OPT_A, 2'b00};
	localparam logic [17:0] AB = {`SOR_IDX_OPT_B, 2'b00};
	localparam logic [17:0] AO = {`SOR_IDX_OSC, 2'b00};
	logic mclk = 0, rstn = 0, por_rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic osc_tick = 0, stop_instr = 0, stop_wake = 0, pready, pslverr, e;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic [7:0] osc_flash_byte = 8'h7F;
	logic [1:0] ph = '0, trip;
	logic [18:0] wdp;
	logic wdd, lvm, ipu, i2r, otb, orun, hold, sen, ill;
	int bad_count = 0, samples_checked = 0, n;
	sor_top #(.REC_SHORT(2), .REC_LONG(8)) sor_top_inst (
		.mclk(mclk), .rstn(rstn), .por_rstn(por_rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_flash_byte(osc_flash_byte), .osc_tick(osc_tick),
		.stop_instr(stop_instr), .stop_wake(stop_wake), .watchdog_period(wdp),
		.watchdog_disable(wdd), .low_voltage_monitor_off(lvm), .trip_voltage_select(trip),
		.irq_pullup_disable(ipu), .i2c_pin_route(i2r), .oscillator_type_bit(otb),
		.osc_run(orun), .cpu_clk_hold(hold), .stop_enter(sen), .illegal_opcode(ill)
	);
	// Clock, and an oscillator tick every fourth cycle
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		ph <= ph + 2'h1;
		osc_tick <= &ph;
	end
	// Verdict and end of run
	task automatic conclude();
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic ck(input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch at %0t seen %0h expected %0h", $time, s, x);
		end
	endtask
	// One APB transfer, held until ready
	task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [17:0] a, input logic [31:0] x);
		bus(1'b0, a, 8'h00);
		ck(r, x);
	endtask
	// Reset for five cycles, then wait out recovery
	task automatic rs(input logic p);
		@(posedge mclk);
		rstn <= 1'b0;
		por_rstn <= p;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		por_rstn <= 1'b1;
		for (n = 0; n < 300 && hold !== 1'b0; n++) @(posedge mclk);
	endtask
	task automatic stp();
		@(posedge mclk);
		stop_instr <= 1'b1;
		@(posedge mclk);
		stop_instr <= 1'b0;
		#1;
	endtask
	task automatic t_reset();
		rd(AA, 32'h0);
		rd(AB, 32'h0);
		rd(AO, 32'h7F);
		ck({otb, wdp}, {1'b0, 19'h3FFF0});
	endtask
	// Option registers keep their first write, later ones ignored
	task automatic t_once();
		bus(1'b1, AA, 8'hFF);
		rd(AA, 32'h97);
		bus(1'b1, AA, 8'h00);
		rd(AA, 32'h97);
		ck({wdp, wdd, lvm}, {19'h01FF0, 2'h3});
		bus(1'b1, AB, 8'hFF);
		bus(1'b1, AB, 8'h00);
		rd(AB, 32'h9B);
		ck({ipu, i2r, trip}, 4'hF);
	endtask
	task automatic t_err();
		bus(1'b1, AO, 8'h00);
		ck(e, 1'b1);
		rd(AO, 32'h7F);
		rd(18'h00040, 32'h0);
		ck(e, 1'b1);
	endtask
	task automatic t_stop();
		stp();
		ck({sen, ill}, 2'h2);
		@(posedge mclk);
		#1;
		ck({orun, hold}, 2'h1);
		@(posedge mclk);
		stop_wake <= 1'b1;
		@(posedge mclk);
		stop_wake <= 1'b0;
		for (n = 0; n < 300 && hold !== 1'b0; n++) @(posedge mclk);
		ck(n <= 16, 1'b1);
	endtask
	// Plain reset keeps trip bits, power-on clears them
	task automatic t_soft();
		stp();
		rs(1'b1);
		ck(n >= 28, 1'b1);
		rd(AA, 32'h0);
		rd(AB, 32'h18);
		bus(1'b1, AB, 8'h81);
		rd(AB, 32'h99);
		ck(otb, 1'b0);
		stp();
		ck({sen, ill}, 2'h1);
		rs(1'b0);
		rd(AB, 32'h0);
		bus(1'b1, AB, 8'h08);
		rd(AB, 32'h08);
		ck(trip, 2'h1);
	endtask
	initial begin
		rs(1'b0);
		t_reset();
		t_once();
		t_err();
		t_stop();
		t_soft();
		conclude();
	end
	initial begin
		#200us;
		bad_count++;
		conclude();
	end
endmodule
bind sor_top sor_top_asserts #(.REC_LONG(REC_LONG)) sor_top_asserts_inst (
	.mclk(mclk), .rstn(rstn), .por_rstn(por_rstn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_period(watchdog_period),
	.watchdog_disable(watchdog_disable), .low_voltage_monitor_off(low_voltage_monitor_off),
	.trip_voltage_select(trip_voltage_select), .irq_pullup_disable(irq_pullup_disable),
	.oscillator_type_bit(oscillator_type_bit), .osc_run(osc_run),
	.cpu_clk_hold(cpu_clk_hold), .stop_enter(stop_enter), .illegal_opcode(illegal_opcode)
);
